// ---- hdl/smfl_supply_monitor.sv ----
// supply monitor flag logic: control register, glitch filters, hold-off timer
// Behaviour
// R01: while enabled, a low on either filtered comparator is a low-supply condition.
// R02: bits 4:3 pick the digital trip point (00 4.63 V, 01 3.08 V, 10 2.93 V, 11 2.63 V) and drive it out.
// R03: bits 2:1 pick the analog trip point with the same encoding and drive it out.
// R04: bit 0 written one enables the monitor, written zero disables it.
// R05: bit 7 reads the digital comparator, one meaning above trip.
// R06: bit 6 reads the analog comparator, one meaning above trip.
// R07: bit 5 is set by hardware while either comparator reports low.
// R08: once both comparators are high again a 250 ms hold-off runs and its expiry clears bit 5.
// R09: software may write bit 5 but cannot clear it while either comparator is low.
// R10: with the matching interrupt enable set, the flag raises the processor interrupt.
// R11: short comparator glitches neither set the flag nor raise the interrupt.
// R12: a new low during the hold-off resets the count until both are high again.
// R13: a low counts only after it lasts a set number of consecutive clock samples.
`timescale 1ns/1ps
`default_nettype none
module smfl_supply_monitor
  import smfl_pkg::*;
#(
  parameter longint HOLDOFF_CYCLES = SMFL_HOLDOFF_CYC,
  parameter int GLITCH_SAMPLES = SMFL_GLITCH_SAMPLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic digital_supply_cmp,
  input wire logic analog_supply_cmp,
  input wire logic secondary_irq_enable_priority,
  output logic [1:0] digital_trip_sel,
  output logic [1:0] analog_trip_sel,
  output logic monitor_enable,
  output logic low_supply_irq
);
  localparam int GW = $clog2(GLITCH_SAMPLES + 1);
  localparam int HW = $clog2(HOLDOFF_CYCLES + 1);
  // a low is trusted only once it has been seen on GLITCH_SAMPLES edges in a row
  localparam logic [GW-1:0] GLITCH_LAST = GW'(GLITCH_SAMPLES);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLDOFF_CYCLES - 1);
  localparam logic [GW-1:0] GZERO = '0;
  localparam logic [HW-1:0] HZERO = '0;
  localparam logic [7:0] RZERO = '0;

  typedef enum logic [1:0] {
    SMFL_IDLE = 2'b00,
    SMFL_LOW = 2'b01,
    SMFL_HOLD = 2'b10
  } smfl_state_t;

  // ****************************************
  // register state
  // ****************************************
  logic [1:0] dtrip_reg;
  logic [1:0] atrip_reg;
  logic enable_reg;
  logic low_supply_irq_flag_reg;
  logic [GW-1:0] dig_cnt_reg;
  logic [GW-1:0] ana_cnt_reg;
  logic [HW-1:0] hold_cnt_reg;
  smfl_state_t state_reg;
  smfl_state_t state_next;
  logic irq_reg;
  logic [7:0] rdata_reg;

  // ****************************************
  // decode
  // ****************************************
  wire logic ctrl_hit = sfr_addr == SMFL_CTRL_ADDR;
  wire logic ctrl_wr = sfr_wr && ctrl_hit;
  wire logic digital_supply_ok = digital_supply_cmp; // R05
  wire logic analog_supply_ok = analog_supply_cmp; // R06
  // a low is trusted only after it outlasts the filter window
  wire logic dig_low = enable_reg && (dig_cnt_reg == GLITCH_LAST); // R13
  wire logic ana_low = enable_reg && (ana_cnt_reg == GLITCH_LAST); // R13
  wire logic supply_low = dig_low || ana_low; // R01 R11
  wire logic hold_done = (state_reg == SMFL_HOLD) && (hold_cnt_reg == HOLD_LAST); // R08
  wire logic sw_set = ctrl_wr && sfr_wdata[SMFL_BIT_FLAG];
  // the clear is judged on the raw comparators, so a low still inside the filter blocks it
  wire logic both_ok = digital_supply_ok && analog_supply_ok;
  wire logic sw_clr = ctrl_wr && !sfr_wdata[SMFL_BIT_FLAG] && both_ok; // R09
  // a hardware or software set beats a clear landing in the same cycle
  wire logic flag_next = supply_low || sw_set
                         || (low_supply_irq_flag_reg && !sw_clr && !hold_done); // R07 R08
  wire logic [7:0] status_word = {digital_supply_ok, analog_supply_ok, low_supply_irq_flag_reg,
                                  dtrip_reg, atrip_reg, enable_reg};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SMFL_IDLE: begin
        if (supply_low) begin
          state_next = SMFL_LOW;
        end
      end
      SMFL_LOW: begin
        if (!supply_low) begin
          state_next = SMFL_HOLD; // R08
        end
      end
      SMFL_HOLD: begin
        if (supply_low) begin
          state_next = SMFL_LOW; // R12
        end else if (hold_done) begin
          state_next = SMFL_IDLE;
        end
      end
      default: begin
        state_next = SMFL_IDLE;
      end
    endcase
  end

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dtrip_reg <= SMFL_CTRL_RESET[SMFL_BIT_DTRIP_HI:SMFL_BIT_DTRIP_LO];
      atrip_reg <= SMFL_CTRL_RESET[SMFL_BIT_ATRIP_HI:SMFL_BIT_ATRIP_LO];
      enable_reg <= SMFL_CTRL_RESET[SMFL_BIT_ENABLE];
    end else if (ctrl_wr) begin
      dtrip_reg <= sfr_wdata[SMFL_BIT_DTRIP_HI:SMFL_BIT_DTRIP_LO]; // R02
      atrip_reg <= sfr_wdata[SMFL_BIT_ATRIP_HI:SMFL_BIT_ATRIP_LO]; // R03
      enable_reg <= sfr_wdata[SMFL_BIT_ENABLE]; // R04
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_supply_irq_flag_reg <= SMFL_CTRL_RESET[SMFL_BIT_FLAG];
    end else begin
      low_supply_irq_flag_reg <= flag_next; // R07
    end
  end

  // ****************************************
  // glitch filters
  // ****************************************
  // counters saturate so a long brownout cannot wrap and look like a fresh glitch
  wire logic dig_clear = digital_supply_ok || !enable_reg;
  wire logic ana_clear = analog_supply_ok || !enable_reg;
  wire logic [GW-1:0] dig_cnt_next = dig_clear ? GZERO
                                     : dig_low ? dig_cnt_reg : dig_cnt_reg + GW'(1); // R13
  wire logic [GW-1:0] ana_cnt_next = ana_clear ? GZERO
                                     : ana_low ? ana_cnt_reg : ana_cnt_reg + GW'(1); // R13

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dig_cnt_reg <= GZERO;
    end else begin
      dig_cnt_reg <= dig_cnt_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ana_cnt_reg <= GZERO;
    end else begin
      ana_cnt_reg <= ana_cnt_next;
    end
  end

  // ****************************************
  // hold-off timer
  // ****************************************
  // a trusted low, or leaving the hold state, restarts the hold-off from zero
  wire logic hold_clear = (state_reg != SMFL_HOLD) || supply_low; // R12
  wire logic [HW-1:0] hold_cnt_next = hold_clear ? HZERO : hold_cnt_reg + HW'(1); // R08

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= SMFL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_cnt_reg <= HZERO;
    end else begin
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  wire logic irq_next = flag_next && secondary_irq_enable_priority; // R10

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // mux before the flop keeps the bus output registered; data lags the address one edge
  wire logic [7:0] rdata_next = ctrl_hit ? status_word : RZERO;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= RZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // registered copies of the trip fields keep outputs flop-driven
  assign digital_trip_sel = dtrip_reg; // R02
  assign analog_trip_sel = atrip_reg; // R03
  assign monitor_enable = enable_reg; // R04
  assign low_supply_irq = irq_reg;
  assign sfr_rdata = rdata_reg;
endmodule
`default_nettype wire

// ---- hdl/smfl_pkg.sv ----
// constants for the supply monitor flag logic
package smfl_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] SMFL_CTRL_ADDR = 8'hdf;
  localparam logic [7:0] SMFL_CTRL_RESET = 8'hde;
  localparam int SMFL_BIT_DIG_OK = 7;
  localparam int SMFL_BIT_ANA_OK = 6;
  localparam int SMFL_BIT_FLAG = 5;
  localparam int SMFL_BIT_DTRIP_HI = 4;
  localparam int SMFL_BIT_DTRIP_LO = 3;
  localparam int SMFL_BIT_ATRIP_HI = 2;
  localparam int SMFL_BIT_ATRIP_LO = 1;
  localparam int SMFL_BIT_ENABLE = 0;
  // ****************************************
  // trip point encodings
  // ****************************************
  localparam logic [1:0] SMFL_TRIP_4V63 = 2'h0;
  localparam logic [1:0] SMFL_TRIP_3V08 = 2'h1;
  localparam logic [1:0] SMFL_TRIP_2V93 = 2'h2;
  localparam logic [1:0] SMFL_TRIP_2V63 = 2'h3;
  // ****************************************
  // timing
  // ****************************************
  localparam longint SMFL_CLK_HZ = 25000000;
  localparam longint SMFL_HOLDOFF_MS = 250;
  localparam longint SMFL_HOLDOFF_CYC = (SMFL_HOLDOFF_MS * SMFL_CLK_HZ) / 1000;
  localparam int SMFL_GLITCH_SAMPLES = 4;
endpackage

// ---- test/smfl_supply_monitor_chk.sv ----
// port assertions for the supply monitor flag logic
`timescale 1ns/1ps
`default_nettype none
module smfl_supply_monitor_chk
  import smfl_pkg::*;
#(
  parameter longint HOLDOFF_CYCLES = SMFL_HOLDOFF_CYC,
  parameter int GLITCH_SAMPLES = SMFL_GLITCH_SAMPLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic digital_supply_cmp,
  input wire logic analog_supply_cmp,
  input wire logic secondary_irq_enable_priority,
  input wire logic [1:0] digital_trip_sel,
  input wire logic [1:0] analog_trip_sel,
  input wire logic monitor_enable,
  input wire logic low_supply_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  int dig_low_cnt;
  int ana_low_cnt;
  longint quiet_cnt;
  wire logic hit = sfr_addr == SMFL_CTRL_ADDR;
  wire logic en = secondary_irq_enable_priority;
  // a comparator low counts once seen on GLITCH_SAMPLES edges in a row while enabled
  wire logic trusted_low = monitor_enable
                           && ((dig_low_cnt == GLITCH_SAMPLES) || (ana_low_cnt == GLITCH_SAMPLES));
  // quiet time since the last trusted low; saturates so it cannot wrap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dig_low_cnt <= 0;
      ana_low_cnt <= 0;
      quiet_cnt <= 0;
    end else begin
      dig_low_cnt <= (digital_supply_cmp || !monitor_enable) ? 0
                     : (dig_low_cnt == GLITCH_SAMPLES) ? dig_low_cnt : dig_low_cnt + 1;
      ana_low_cnt <= (analog_supply_cmp || !monitor_enable) ? 0
                     : (ana_low_cnt == GLITCH_SAMPLES) ? ana_low_cnt : ana_low_cnt + 1;
      quiet_cnt <= trusted_low ? 0 : (quiet_cnt >= HOLDOFF_CYCLES) ? quiet_cnt : quiet_cnt + 1;
    end
  end
  a_dig_trip: assert property (hit && sfr_wr |=> digital_trip_sel == $past(sfr_wdata[4:3]))
    else $error("digital trip select wrong");
  a_ana_trip: assert property (hit && sfr_wr |=> analog_trip_sel == $past(sfr_wdata[2:1]))
    else $error("analog trip select wrong");
  a_enable_write: assert property (hit && sfr_wr |=> monitor_enable == $past(sfr_wdata[0]))
    else $error("monitor enable wrong");
  a_dig_mirror: assert property ($past(hit) && !$past(rst) |->
    sfr_rdata[7] == $past(digital_supply_cmp)) else $error("digital status wrong");
  a_ana_mirror: assert property ($past(hit) && !$past(rst) |->
    sfr_rdata[6] == $past(analog_supply_cmp)) else $error("analog status wrong");
  a_irq_gated: assert property (low_supply_irq |-> $past(en))
    else $error("interrupt without enable");
  a_flag_cause: assert property ($rose(low_supply_irq) |->
    $past(sfr_wr) || $past(trusted_low) || !$past(en, 2)) else $error("interrupt without low");
  a_holdoff_wait: assert property ($fell(low_supply_irq) && $past(en) && !$past(sfr_wr) |->
    quiet_cnt >= HOLDOFF_CYCLES) else $error("flag cleared early");
endmodule
bind smfl_supply_monitor smfl_supply_monitor_chk #(
  .HOLDOFF_CYCLES(HOLDOFF_CYCLES),
  .GLITCH_SAMPLES(GLITCH_SAMPLES)
) smfl_supply_monitor_chk_inst (
  .clock(clock),
  .rst(rst),
  .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .digital_supply_cmp(digital_supply_cmp),
  .analog_supply_cmp(analog_supply_cmp),
  .secondary_irq_enable_priority(secondary_irq_enable_priority),
  .digital_trip_sel(digital_trip_sel),
  .analog_trip_sel(analog_trip_sel),
  .monitor_enable(monitor_enable),
  .low_supply_irq(low_supply_irq)
);
`default_nettype wire

// ---- test/smfl_cmp_model.sv ----
// behavioural model of the two supply comparators, supplies in millivolts
`timescale 1ns/1ps
`default_nettype none
module smfl_cmp_model (
  input wire logic [1:0] digital_trip_sel,
  input wire logic [1:0] analog_trip_sel,
  input wire logic [15:0] dig_mv,
  input wire logic [15:0] ana_mv,
  output logic digital_supply_cmp,
  output logic analog_supply_cmp
);
  localparam int TRIP [4] = '{4630, 3080, 2930, 2630};
  assign digital_supply_cmp = dig_mv > TRIP[digital_trip_sel];
  assign analog_supply_cmp = ana_mv > TRIP[analog_trip_sel];
endmodule
`default_nettype wire

// ---- test/smfl_supply_monitor_test.sv ----
// self-checking bench for the supply monitor flag logic
`timescale 1ns/1ps
`default_nettype none
module smfl_supply_monitor_test;
  import smfl_pkg::*;
  localparam int TRIP [4] = '{4630, 3080, 2930, 2630};
  logic clock = 0, rst = 1, sfr_wr = 0, irq_en = 1, dcmp, acmp, men, irq;
  logic [7:0] sfr_addr = SMFL_CTRL_ADDR, sfr_wdata = 8'h00, sfr_rdata, v;
  logic [1:0] dsel, asel;
  logic [15:0] dmv = 16'h1388, amv = 16'h1388;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  wire logic [8:0] obs = {irq, sfr_rdata};
  initial forever #20 clock = ~clock;
  smfl_supply_monitor #(.HOLDOFF_CYCLES(20), .GLITCH_SAMPLES(4)) smfl_supply_monitor_inst (
    .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .digital_supply_cmp(dcmp), .analog_supply_cmp(acmp),
    .secondary_irq_enable_priority(irq_en), .digital_trip_sel(dsel), .analog_trip_sel(asel),
    .monitor_enable(men), .low_supply_irq(irq));
  smfl_cmp_model smfl_cmp_model_inst (.digital_trip_sel(dsel), .analog_trip_sel(asel),
    .dig_mv(dmv), .ana_mv(amv), .digital_supply_cmp(dcmp), .analog_supply_cmp(acmp));
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // expected comparator level for a supply in millivolts against a trip code
  function automatic logic above_trip(logic [15:0] mv, logic [1:0] sel);
    return mv > TRIP[sel];
  endfunction
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(negedge clock);
    sfr_wr = 0;
    sfr_addr = SMFL_CTRL_ADDR;
    @(negedge clock);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'h0000_96da));
    repeat (20) @(negedge clock);
    rst = 0;
    @(negedge clock);
    chk("reset", {1'b0, SMFL_CTRL_RESET}, obs);
    chk("reset fields", 9'(SMFL_CTRL_RESET[4:0]), {dsel, asel, men});
    // flag bit masked here: random supplies may set it at any time
    for (int i = 0; i < 12; i++) begin
      v = 8'($urandom % 32);
      dmv = 16'(2600 + $urandom % 2100);
      amv = 16'(2600 + $urandom % 2100);
      wr(SMFL_CTRL_ADDR, v);
      chk("sel", 9'(v[4:0]), {dsel, asel, men});
      chk("ctrl", {above_trip(dmv, v[4:3]), above_trip(amv, v[2:1]), 1'b0, v[4:0]},
          sfr_rdata & 8'hdf);
    end
    dmv = 16'h1388;
    amv = 16'h1388;
    repeat (6) @(negedge clock);
    wr(SMFL_CTRL_ADDR, 8'h01);
    chk("clear", 9'h0c1, obs);
    dmv = 16'h0fa0;
    repeat (2) @(negedge clock);
    dmv = 16'h1388;
    repeat (4) @(negedge clock);
    chk("glitch", 9'h0c1, obs);
    amv = 16'h07d0;
    repeat (8) @(negedge clock);
    chk("low", 9'h1a1, obs);
    wr(SMFL_CTRL_ADDR, 8'h01);
    chk("noclear", 9'h1a1, obs);
    amv = 16'h1388;
    repeat (8) @(negedge clock);
    dmv = 16'h0fa0;
    repeat (6) @(negedge clock);
    dmv = 16'h1388;
    repeat (16) @(negedge clock);
    chk("hold", 9'h1e1, obs);
    repeat (12) @(negedge clock);
    chk("expire", 9'h0c1, obs);
    irq_en = 0;
    dmv = 16'h07d0;
    repeat (8) @(negedge clock);
    chk("masked", 9'h061, obs);
    wr(8'h10, 8'h1e);
    chk("unmapped", 9'h061, obs);
    tally_and_finish();
  end
endmodule
`default_nettype wire
